// ---- rtl/rbs_map.vh ----
// Register offsets, field positions, reset values and counts of the bias and synth bank
`ifndef RBS_MAP_VH
`define RBS_MAP_VH

// Register offsets on the configuration port
`define RBS_ADDR_RX_BIAS 6'h17
`define RBS_ADDR_SYNTH 6'h18

// Receive bias control fields
`define RBS_RX_RSVD_HI 15
`define RBS_RX_RSVD_LO 14
`define RBS_RX_BPF_LOW 13
`define RBS_RX_BPF_MID 12
`define RBS_RX_LNA_LOW 11
`define RBS_RX_LNA_MED 10
`define RBS_RX_MIX_HIGH 9
`define RBS_RX_MIX_MED 8
`define RBS_RX_VAR_HI 7
`define RBS_RX_VAR_LO 6
`define RBS_RX_TAIL_HI 5
`define RBS_RX_TAIL_LO 4
`define RBS_RX_VCM_HI 3
`define RBS_RX_VCM_LO 2
`define RBS_RX_CUR_HI 1
`define RBS_RX_CUR_LO 0

// Receive bias control reset values
`define RBS_RST_BPF_LOW 1'h0
`define RBS_RST_BPF_MID 1'h0
`define RBS_RST_LNA_LOW 1'h1
`define RBS_RST_LNA_MED 1'h0
`define RBS_RST_MIX_HIGH 1'h1
`define RBS_RST_MIX_MED 1'h0
`define RBS_RST_VAR 2'h1
`define RBS_RST_TAIL 2'h1
`define RBS_RST_VCM 2'h1
`define RBS_RST_CUR 2'h2

// Synth control and status fields
`define RBS_FS_THR_HI 15
`define RBS_FS_THR_LO 14
`define RBS_FS_CAL_DONE 13
`define RBS_FS_CAL_ACTIVE 12
`define RBS_FS_WIN_WIDE 11
`define RBS_FS_LOCKED 10
`define RBS_FS_FREQ_HI 9
`define RBS_FS_FREQ_LO 0

// Synth control reset values
`define RBS_RST_THR 2'h1
`define RBS_RST_WIN_WIDE 1'h0
`define RBS_RST_FREQ 10'h165

// Carrier base, receive offset (MHz) and lock count base (reference periods)
`define RBS_FREQ_BASE_MHZ 12'h800
`define RBS_RX_LO_OFFSET_MHZ 12'h002
`define RBS_LOCK_BASE_PERIODS 10'h040

// Gain step codes
`define RBS_STEP_LOW 2'h0
`define RBS_STEP_MED 2'h1
`define RBS_STEP_HIGH 2'h2

`endif

// ---- rtl/rbs_bias_synth_regs.v ----
// Receive bias and synthesizer control/status register bank with lock detector
`timescale 1ns/10ps
`include "rbs_map.vh"

module rbs_bias_synth_regs #(
	parameter ADDR_W = 6,
	parameter CNT_W = 10
) (
	input wire mclk,
	input wire arst_n,
	input wire [ADDR_W-1:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	input wire [1:0] automatic_gain_step,
	input wire tx_mode,
	input wire synth_on,
	input wire cal_start,
	input wire cal_finish,
	input wire ref_tick,
	input wire window_ok,
	output reg bandpass_bias_low_sel,
	output reg bandpass_bias_mid_sel,
	output reg low_noise_amp_lowgain,
	output reg mixer_highgain,
	output reg [1:0] lna_varactor_sel,
	output reg [1:0] mixer_output_current_sel,
	output reg [1:0] mixer_common_mode_sel,
	output reg [1:0] mixer_core_current_sel,
	output reg lock_window_wide,
	output reg [9:0] carrier_freq_word,
	output reg [11:0] lo_freq_mhz,
	output reg calibration_active_flag,
	output reg calibration_done_flag,
	output reg synth_locked
);

	// Lock detector states, one-hot
	localparam [2:0] ST_OFF = 3'b001;
	localparam [2:0] ST_SEARCH = 3'b010;
	localparam [2:0] ST_LOCKED = 3'b100;

	// Count step sized to the counter so the increment neither pads nor drops bits
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	// Gain-step selection bits and the lock count threshold held in the registers
	reg lna_lowgain_at_agc_low;
	reg lna_lowgain_at_agc_med;
	reg mixer_highgain_at_agc_high;
	reg mixer_highgain_at_agc_med;
	reg [1:0] lock_count_threshold;

	reg [2:0] lock_state;
	reg [2:0] next_lock_state;
	reg [CNT_W-1:0] good_count;
	reg [CNT_W-1:0] next_good_count;
	reg synth_on_d;
	reg next_lna_lowgain;
	reg next_mixer_highgain;
	reg [15:0] next_rdata;
	reg [11:0] next_lo_freq;
	reg [CNT_W-1:0] lock_target;

	wire wr_rx = reg_wr && (reg_addr == `RBS_ADDR_RX_BIAS);
	wire wr_fs = reg_wr && (reg_addr == `RBS_ADDR_SYNTH);
	wire synth_power_up = synth_on && !synth_on_d;

	// threshold code to a period count; a case keeps every code explicit
	always @* begin
		lock_target = `RBS_LOCK_BASE_PERIODS;
		case (lock_count_threshold)
			2'h0: begin
				lock_target = `RBS_LOCK_BASE_PERIODS;
			end
			2'h1: begin
				lock_target = `RBS_LOCK_BASE_PERIODS << 1;
			end
			2'h2: begin
				lock_target = `RBS_LOCK_BASE_PERIODS << 2;
			end
			2'h3: begin
				lock_target = `RBS_LOCK_BASE_PERIODS << 3;
			end
			default: begin
				lock_target = `RBS_LOCK_BASE_PERIODS;
			end
		endcase
	end

	// Receive bias register writes; reserved top bits are not stored
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bandpass_bias_low_sel <= `RBS_RST_BPF_LOW;
			bandpass_bias_mid_sel <= `RBS_RST_BPF_MID;
			lna_lowgain_at_agc_low <= `RBS_RST_LNA_LOW;
			lna_lowgain_at_agc_med <= `RBS_RST_LNA_MED;
			mixer_highgain_at_agc_high <= `RBS_RST_MIX_HIGH;
			mixer_highgain_at_agc_med <= `RBS_RST_MIX_MED;
			lna_varactor_sel <= `RBS_RST_VAR;
			mixer_output_current_sel <= `RBS_RST_TAIL;
			mixer_common_mode_sel <= `RBS_RST_VCM;
			mixer_core_current_sel <= `RBS_RST_CUR;
		end else if (wr_rx) begin
			bandpass_bias_low_sel <= reg_wdata[`RBS_RX_BPF_LOW];
			bandpass_bias_mid_sel <= reg_wdata[`RBS_RX_BPF_MID];
			lna_lowgain_at_agc_low <= reg_wdata[`RBS_RX_LNA_LOW];
			lna_lowgain_at_agc_med <= reg_wdata[`RBS_RX_LNA_MED];
			mixer_highgain_at_agc_high <= reg_wdata[`RBS_RX_MIX_HIGH];
			mixer_highgain_at_agc_med <= reg_wdata[`RBS_RX_MIX_MED];
			lna_varactor_sel <= reg_wdata[`RBS_RX_VAR_HI:`RBS_RX_VAR_LO];
			mixer_output_current_sel <= reg_wdata[`RBS_RX_TAIL_HI:`RBS_RX_TAIL_LO];
			mixer_common_mode_sel <= reg_wdata[`RBS_RX_VCM_HI:`RBS_RX_VCM_LO];
			mixer_core_current_sel <= reg_wdata[`RBS_RX_CUR_HI:`RBS_RX_CUR_LO];
		end
	end

	// Synth control writes; status bit positions are skipped
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lock_count_threshold <= `RBS_RST_THR;
			lock_window_wide <= `RBS_RST_WIN_WIDE;
			carrier_freq_word <= `RBS_RST_FREQ;
		end else if (wr_fs) begin
			// Status positions come from live logic; a stored copy would go stale
			// status bits ignored
			lock_count_threshold <= reg_wdata[`RBS_FS_THR_HI:`RBS_FS_THR_LO];
			lock_window_wide <= reg_wdata[`RBS_FS_WIN_WIDE];
			carrier_freq_word <= reg_wdata[`RBS_FS_FREQ_HI:`RBS_FS_FREQ_LO];
		end
	end

	// Gain-mode selection per AUTOMATIC_GAIN_STEP step; the high step keeps the LOW_NOISE_AMP at full gain
	always @* begin
		next_lna_lowgain = 1'b0;
		next_mixer_highgain = 1'b0;
		case (automatic_gain_step)
			`RBS_STEP_LOW: begin
				next_lna_lowgain = lna_lowgain_at_agc_low;
			end
			`RBS_STEP_MED: begin
				next_lna_lowgain = lna_lowgain_at_agc_med;
				next_mixer_highgain = mixer_highgain_at_agc_med;
			end
			`RBS_STEP_HIGH: begin
				next_mixer_highgain = mixer_highgain_at_agc_high;
			end
			default: begin
				// Code 3 selects no step: full LOW_NOISE_AMP gain, normal mixer gain
				next_lna_lowgain = 1'b0;
				next_mixer_highgain = 1'b0;
			end
		endcase
	end

	// LO frequency: receive sits below the carrier for the low IF
	always @* begin
		// Base plus the largest word still fits in 12 bits, so no wrap
		next_lo_freq = `RBS_FREQ_BASE_MHZ + {2'h0, carrier_freq_word};
		if (!tx_mode) begin
			next_lo_freq = next_lo_freq - `RBS_RX_LO_OFFSET_MHZ;
		end
	end

	// Gain and LO outputs registered so analog controls never glitch
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			low_noise_amp_lowgain <= 1'b0;
			mixer_highgain <= 1'b0;
			lo_freq_mhz <= 12'h000;
		end else begin
			low_noise_amp_lowgain <= next_lna_lowgain;
			mixer_highgain <= next_mixer_highgain;
			lo_freq_mhz <= next_lo_freq;
		end
	end

	// Calibration flags; a start in the same cycle as a finish wins at the active flag but done sets if a run was active, and power-off clears over a start
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			synth_on_d <= 1'b0;
			calibration_active_flag <= 1'b0;
			calibration_done_flag <= 1'b0;
		end else begin
			synth_on_d <= synth_on;
			if (!synth_on) begin
				calibration_active_flag <= 1'b0;
			end else if (cal_start) begin
				calibration_active_flag <= 1'b1;
			end else if (cal_finish) begin
				calibration_active_flag <= 1'b0;
			end
			// A finish with no run in progress is ignored, so a stray pulse never sets done
			// done since power-on
			if (synth_on && cal_finish && calibration_active_flag) begin
				calibration_done_flag <= 1'b1;
			end else if (!synth_on || synth_power_up) begin
				calibration_done_flag <= 1'b0;
			end
		end
	end

	// Lock detector next state, evaluated every clock; the count moves only on ref_tick or at power-off
	always @* begin
		next_lock_state = lock_state;
		next_good_count = good_count;
		case (lock_state)
			ST_OFF: begin
				next_good_count = {CNT_W{1'b0}};
				if (synth_on) begin
					next_lock_state = ST_SEARCH;
				end
			end
			ST_SEARCH: begin
				if (!synth_on) begin
					next_lock_state = ST_OFF;
					next_good_count = {CNT_W{1'b0}};
				end else if (ref_tick && !window_ok) begin
					next_good_count = {CNT_W{1'b0}};
				end else if (ref_tick) begin
					next_good_count = good_count + CNT_ONE;
					// At or past the target, so a threshold lowered mid-count still locks
					if (next_good_count >= lock_target) begin
						next_lock_state = ST_LOCKED;
					end
				end
			end
			ST_LOCKED: begin
				// Raising the threshold later keeps an existing lock
				if (!synth_on) begin
					next_lock_state = ST_OFF;
					next_good_count = {CNT_W{1'b0}};
				end else if (ref_tick && !window_ok) begin
					next_lock_state = ST_SEARCH;
					next_good_count = {CNT_W{1'b0}};
				end
			end
			default: begin
				next_lock_state = ST_OFF;
				next_good_count = {CNT_W{1'b0}};
			end
		endcase
	end

	// Lock detector registers and indicator
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lock_state <= ST_OFF;
			good_count <= {CNT_W{1'b0}};
			synth_locked <= 1'b0;
		end else begin
			lock_state <= next_lock_state;
			good_count <= next_good_count;
			// Follows the next state so it rises on the tick that completes the run
			// lock indicator
			synth_locked <= (next_lock_state == ST_LOCKED);
		end
	end

	// Read mux; reserved and unmapped addresses read as zero
	always @* begin
		// A read in the same cycle as a write returns the old contents
		next_rdata = 16'h0000;
		case (reg_addr)
			`RBS_ADDR_RX_BIAS: begin
				next_rdata[`RBS_RX_BPF_LOW] = bandpass_bias_low_sel;
				next_rdata[`RBS_RX_BPF_MID] = bandpass_bias_mid_sel;
				next_rdata[`RBS_RX_LNA_LOW] = lna_lowgain_at_agc_low;
				next_rdata[`RBS_RX_LNA_MED] = lna_lowgain_at_agc_med;
				next_rdata[`RBS_RX_MIX_HIGH] = mixer_highgain_at_agc_high;
				next_rdata[`RBS_RX_MIX_MED] = mixer_highgain_at_agc_med;
				next_rdata[`RBS_RX_VAR_HI:`RBS_RX_VAR_LO] = lna_varactor_sel;
				next_rdata[`RBS_RX_TAIL_HI:`RBS_RX_TAIL_LO] = mixer_output_current_sel;
				next_rdata[`RBS_RX_VCM_HI:`RBS_RX_VCM_LO] = mixer_common_mode_sel;
				next_rdata[`RBS_RX_CUR_HI:`RBS_RX_CUR_LO] = mixer_core_current_sel;
			end
			`RBS_ADDR_SYNTH: begin
				next_rdata[`RBS_FS_THR_HI:`RBS_FS_THR_LO] = lock_count_threshold;
				next_rdata[`RBS_FS_CAL_DONE] = calibration_done_flag;
				next_rdata[`RBS_FS_CAL_ACTIVE] = calibration_active_flag;
				next_rdata[`RBS_FS_WIN_WIDE] = lock_window_wide;
				next_rdata[`RBS_FS_LOCKED] = synth_locked;
				next_rdata[`RBS_FS_FREQ_HI:`RBS_FS_FREQ_LO] = carrier_freq_word;
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// Read data captured on the read strobe and held until the next read
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			// Status is a snapshot at the strobe; a later change needs a new read
			reg_rdata <= next_rdata;
		end
	end

endmodule // rbs_bias_synth_regs

// ---- verif/rbs_bias_synth_regs_checker.sv ----
// Port assertions for the bias and synth register bank
`timescale 1ns/10ps
module rbs_bias_synth_regs_checker #(
	parameter ADDR_W = 6
) (
	input wire mclk,
	input wire arst_n,
	input wire [ADDR_W-1:0] reg_addr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire [1:0] automatic_gain_step,
	input wire tx_mode,
	input wire synth_on,
	input wire cal_start,
	input wire cal_finish,
	input wire ref_tick,
	input wire window_ok,
	input wire low_noise_amp_lowgain,
	input wire [9:0] carrier_freq_word,
	input wire [11:0] lo_freq_mhz,
	input wire calibration_active_flag,
	input wire calibration_done_flag,
	input wire synth_locked
);
	reg [9:0] good;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Good ticks in a row; never below the design's count, so a floor is safe
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			good <= 10'h000;
		else if (!synth_on || (ref_tick && !window_ok))
			good <= 10'h000;
		else if (ref_tick && good != 10'h3FF)
			good <= good + 10'h001;
	end
	a_lo_freq: assert property ($past(arst_n) |-> lo_freq_mhz ==
		($past(tx_mode) ? 12'h800 : 12'h7FE) + $past(carrier_freq_word)) else $error("lo wrong");
	a_lna_off: assert property ($past(automatic_gain_step[1]) |-> !low_noise_amp_lowgain)
		else $error("lna low gain at high step");
	a_lock_floor: assert property ($rose(synth_locked) |-> good >= 10'h040)
		else $error("lock too early");
	a_lock_drop: assert property (synth_on && ref_tick && !window_ok |=> !synth_locked)
		else $error("lock kept after bad window");
	a_synth_off: assert property (!synth_on |=> !synth_locked && !calibration_done_flag
		&& !calibration_active_flag) else $error("status set while off");
	a_cal_start: assert property (synth_on && cal_start |=> calibration_active_flag)
		else $error("cal not active");
	a_cal_done: assert property (synth_on && calibration_active_flag && cal_finish &&
		!cal_start |=> calibration_done_flag && !calibration_active_flag) else $error("no done");
	a_unmapped_read: assert property (reg_rd && reg_addr != 6'h17 && reg_addr != 6'h18 |=>
		reg_rdata == 16'h0000) else $error("unmapped read not zero");
	c_lock: cover property ($rose(synth_locked));
	c_cal_done: cover property ($rose(calibration_done_flag));
	c_unmapped: cover property (reg_rd && reg_addr == 6'h19);
endmodule // rbs_bias_synth_regs_checker

bind rbs_bias_synth_regs rbs_bias_synth_regs_checker #(.ADDR_W(ADDR_W))
	rbs_bias_synth_regs_checker_i (.mclk, .arst_n, .reg_addr, .reg_rd, .reg_rdata,
	.automatic_gain_step, .tx_mode, .synth_on, .cal_start, .cal_finish, .ref_tick, .window_ok,
	.low_noise_amp_lowgain, .carrier_freq_word, .lo_freq_mhz, .calibration_active_flag,
	.calibration_done_flag, .synth_locked);

// ---- verif/rbs_host_model.sv ----
// Host model driving the configuration port
`timescale 1ns/10ps
module rbs_host_model (
	input wire mclk,
	output reg [5:0] reg_addr,
	output reg reg_wr,
	output reg reg_rd,
	output reg [15:0] reg_wdata
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 24'h000000;
	// One strobe cycle; data flips once released so nothing leans on stale data
	task wr(input [5:0] a, input [15:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_wr <= 1'b1;
			// reserved top bits written as zero
			reg_wdata <= (a == 6'h17) ? (d & 16'h3FFF) : d;
			@(posedge mclk);
			reg_wr <= 1'b0;
			reg_wdata <= ~reg_wdata;
		end
	endtask
	task rd(input [5:0] a);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
		end
	endtask
endmodule // rbs_host_model

// ---- verif/rbs_bias_synth_regs_tb.sv ----
// Self-checking bench for the bias and synth register bank
`timescale 1ns/10ps
module rbs_bias_synth_regs_tb;
	reg mclk, arst_n, tx_mode, synth_on, cal_start, cal_finish, ref_tick, window_ok, seen;
	reg [1:0] automatic_gain_step;
	wire [5:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, bandpass_bias_low_sel, bandpass_bias_mid_sel, low_noise_amp_lowgain;
	wire mixer_highgain, lock_window_wide, calibration_active_flag, calibration_done_flag;
	wire synth_locked;
	wire [1:0] lna_varactor_sel, mixer_output_current_sel, mixer_common_mode_sel;
	wire [1:0] mixer_core_current_sel;
	wire [9:0] carrier_freq_word;
	wire [11:0] lo_freq_mhz;
	wire [15:0] fld = {2'h0, bandpass_bias_low_sel, bandpass_bias_mid_sel, 4'h0, lna_varactor_sel,
		mixer_output_current_sel, mixer_common_mode_sel, mixer_core_current_sel};
	integer fails = 0, checks = 0, cycles = 0, i, n;
	reg [31:0] seed;
	reg [15:0] d;
	reg [15:0] exp_q[$];
	rbs_bias_synth_regs rbs_bias_synth_regs_i (.*);
	rbs_host_model rbs_host_model_i (.*);
	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task check(input [15:0] got, input [15:0] want, input string what);
		begin
			checks = checks + 1;
			if (got !== want) begin
				fails = fails + 1;
				$display("ERROR %s expected %h seen %h", what, want, got);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d fails %0d", checks, fails);
			if (fails == 0 && checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task rd(input [5:0] a, input [15:0] e);
		begin
			exp_q.push_back(e);
			rbs_host_model_i.rd(a);
		end
	endtask
	task step(input tk, input ok, input s, input f);
		begin
			@(posedge mclk);
			{ref_tick, window_ok, cal_start, cal_finish} <= {tk, ok, s, f};
		end
	endtask
	// One driven edge, one quiet edge, then let the results land
	task pulse(input tk, input ok, input s, input f);
		begin
			step(tk, ok, s, f);
			step(1'b0, 1'b0, 1'b0, 1'b0);
			#1;
		end
	endtask
	// Read data lands one edge after the strobe; the oldest note is due
	always @(posedge mclk)
		seen <= reg_rd;
	always @(negedge mclk)
		if (seen)
			check(reg_rdata, exp_q.pop_front(), "rdata");
	// Hang guard, far above the run length
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			finish_test;
		end
	end
	initial begin
		arst_n = 1'b0;
		seed = 32'hCEE1;
		automatic_gain_step = 2'h3;
		{tx_mode, synth_on, cal_start, cal_finish, ref_tick, window_ok} = 6'h00;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		rd(6'h17, 16'h0A56);
		rd(6'h18, 16'h4165);
		check(lo_freq_mhz, 16'h0963, "lo reset");
		rbs_host_model_i.wr(6'h19, 16'hFFFF);
		rd(6'h19, 16'h0000);
		rd(6'h17, 16'h0A56);
		$display("test reset and map done");
		// Random words, every gain step and both LO modes
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			d = seed[15:0];
			rbs_host_model_i.wr(6'h17, d);
			tx_mode <= seed[16];
			#1;
			check(fld, d & 16'h30FF, "bias fields");
			for (n = 0; n < 4; n = n + 1) begin
				@(posedge mclk);
				automatic_gain_step <= n[1:0];
				@(posedge mclk);
				#1;
				check(low_noise_amp_lowgain, n == 0 ? d[11] : n == 1 && d[10], "lna");
				check(mixer_highgain, n == 2 ? d[9] : n == 1 && d[8], "mixer");
			end
			rbs_host_model_i.wr(6'h18, ~d);
			rd(6'h18, ~d & 16'hCBFF);
			check({lock_window_wide, carrier_freq_word}, {~d[11], ~d[9:0]},
				"synth fields");
			check(lo_freq_mhz, (tx_mode ? 16'h0800 : 16'h07FE) + (~d & 16'h03FF), "lo");
		end
		$display("test random fields done");
		// Lock at every threshold code, lost on one bad window
		@(posedge mclk);
		synth_on <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			rbs_host_model_i.wr(6'h18, {i[1:0], 14'h0165});
			step(1'b1, 1'b0, 1'b0, 1'b0);
			for (n = 1; n < (64 << i); n = n + 1)
				step(1'b1, 1'b1, 1'b0, 1'b0);
			pulse(1'b0, 1'b0, 1'b0, 1'b0);
			check(synth_locked, 1'b0, "early lock");
			pulse(1'b1, 1'b1, 1'b0, 1'b0);
			check(synth_locked, 1'b1, "lock");
			rd(6'h18, {i[1:0], 4'h1, 10'h165});
			pulse(1'b1, 1'b0, 1'b0, 1'b0);
			check(synth_locked, 1'b0, "unlock");
		end
		// Threshold lowered below a running count still locks
		for (n = 0; n < 100; n = n + 1)
			step(1'b1, 1'b1, 1'b0, 1'b0);
		rbs_host_model_i.wr(6'h18, 16'h0165);
		pulse(1'b1, 1'b1, 1'b0, 1'b0);
		check(synth_locked, 1'b1, "lock lowered");
		$display("test lock done");
		// Calibration run while locked, then power-off clears and refuses it
		pulse(1'b0, 1'b0, 1'b1, 1'b0);
		check(calibration_active_flag, 1'b1, "cal active");
		rd(6'h18, 16'h1565);
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		check({calibration_done_flag, calibration_active_flag}, 16'h0002,
			"cal done");
		rd(6'h18, 16'h2565);
		synth_on <= 1'b0;
		pulse(1'b0, 1'b0, 1'b1, 1'b0);
		check({calibration_done_flag, calibration_active_flag, synth_locked}, 16'h0000,
			"cal off");
		$display("test calibration done");
		finish_test;
	end
endmodule // rbs_bias_synth_regs_tb
